//--- core/adc_readout_regs.svh
`ifndef ADC_READOUT_REGS_SVH
`define ADC_READOUT_REGS_SVH

// ==========================================================
// Word and conversion timing
`define WORD_BITS      8
`define CONV_LAST      6'd35
`define CONV_FIRST_DEC 6'd7
`define STEP_PHASE     2'd3
`define CONV_MAX_NS    17000
`define CLK_NS         100
`define CONV_MAX_CYC   (`CONV_MAX_NS / `CLK_NS)

// ==========================================================
// Serial framing
`define EDGE_LAST      3'd7
`define SAMPLE_EDGE    3'd4
`define CS_FILT_LAST   2'd2

// ==========================================================
// Analog window and codes
`define AIN_BITS       10
`define REF_LO         10'h080
`define REF_HI         10'h180
`define CODE_MAX       8'hff
`define CODE_MIN       8'h00
`define RESULT_RST     8'h00
`define TRIAL_RST      8'h80

`endif

//--- core/adc_readout_pkg.sv
package adc_readout_pkg;

    // ======================================================
    // Converter states
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_DONE
    } conv_state_t;

    typedef logic [7:0] code_t;

endpackage

//--- core/result_buf_if.sv
`timescale 1ns/10ps
`default_nettype none

interface result_buf_if;
    import adc_readout_pkg::*;

    logic  push_valid;
    logic  push_ready;
    code_t push_data;
    logic  pop_valid;
    logic  pop_ready;
    code_t pop_data;

    modport buffer (
        input  push_valid,
        input  push_data,
        input  pop_ready,
        output push_ready,
        output pop_valid,
        output pop_data
    );

    modport user (
        output push_valid,
        output push_data,
        output pop_ready,
        input  push_ready,
        input  pop_valid,
        input  pop_data
    );
endinterface

`default_nettype wire

//--- core/result_buf.sv
`timescale 1ns/10ps
`default_nettype none

module result_buf
    import adc_readout_pkg::*;
(
    // Clock and reset
    input wire logic    clock,
    input wire logic    resetn,
    // Both sides of the buffer
    result_buf_if.buffer rb
);
    // ======================================================
    // Two entries, so a converter result survives a late reader.
    code_t      mem [2];
    logic       wr_ptr_r;
    logic       rd_ptr_r;
    logic [1:0] count_r;
    logic       push_fire;
    logic       pop_fire;

    assign rb.push_ready = (count_r != 2'd2);
    assign rb.pop_valid  = (count_r != 2'd0);
    assign rb.pop_data   = mem[rd_ptr_r];
    assign push_fire     = rb.push_valid & rb.push_ready;
    assign pop_fire      = rb.pop_valid & rb.pop_ready;

    always_ff @(posedge clock) begin
        if (push_fire) begin
            mem[wr_ptr_r] <= rb.push_data;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'd0;
        end else begin
            wr_ptr_r <= wr_ptr_r ^ push_fire;
            rd_ptr_r <= rd_ptr_r ^ pop_fire;
            count_r  <= count_r + {1'b0, push_fire} - {1'b0, pop_fire};
        end
    end

endmodule

`default_nettype wire

//--- core/serial_adc_readout.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_readout_regs.svh"

module serial_adc_readout
    import adc_readout_pkg::*;
(
    // Internal system clock and reset
    input  wire logic                  clock,
    input  wire logic                  resetn,
    // Serial link from the host
    input  wire logic                  shift_clk,
    input  wire logic                  chip_sel_n,
    // Three-state serial result
    output logic                       data_out,
    output logic                       data_oe,
    // Digitised analog input level
    input  wire logic [`AIN_BITS-1:0]  analog_in
);
    localparam int CONV_MAX = `CONV_MAX_CYC;

    // ======================================================
    // Link domain: edge counting on the shift clock
    logic [2:0] edge_cnt_r;
    logic       conv_req_r;
    logic       sample_r;
    logic       link_rst_n;

    // A raised chip select clears the frame at once; the host
    // guarantees setup before the first shift-clock edge.
    assign link_rst_n = resetn & ~chip_sel_n;

    always_ff @(negedge shift_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            edge_cnt_r <= 3'd0;
            sample_r   <= 1'b0;
        end else begin
            edge_cnt_r <= edge_cnt_r + 3'd1;
            sample_r   <= (edge_cnt_r >= `SAMPLE_EDGE) &
                          (edge_cnt_r != `EDGE_LAST);
        end
    end

    // The request toggle survives chip select so the event is not
    // lost when the host raises it right after the eighth edge.
    always_ff @(negedge shift_clk or negedge resetn) begin
        if (!resetn) begin
            conv_req_r <= 1'b0;
        end else if (edge_cnt_r == `EDGE_LAST) begin
            conv_req_r <= ~conv_req_r;
        end
    end

    // ======================================================
    // Crossings into the internal clock domain
    logic                 req_s1_r;
    logic                 req_s2_r;
    logic                 req_s3_r;
    logic                 samp_s1_r;
    logic                 samp_s2_r;
    logic                 cs_s1_r;
    logic                 cs_s2_r;
    logic [`AIN_BITS-1:0] ain_s1_r;
    logic [`AIN_BITS-1:0] ain_s2_r;
    logic                 start;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            req_s1_r  <= 1'b0;
            req_s2_r  <= 1'b0;
            req_s3_r  <= 1'b0;
            samp_s1_r <= 1'b0;
            samp_s2_r <= 1'b0;
            cs_s1_r   <= 1'b1;
            cs_s2_r   <= 1'b1;
            ain_s1_r  <= '0;
            ain_s2_r  <= '0;
        end else begin
            req_s1_r  <= conv_req_r;
            req_s2_r  <= req_s1_r;
            req_s3_r  <= req_s2_r;
            samp_s1_r <= sample_r;
            samp_s2_r <= samp_s1_r;
            cs_s1_r   <= chip_sel_n;
            cs_s2_r   <= cs_s1_r;
            ain_s1_r  <= analog_in;
            ain_s2_r  <= ain_s1_r;
        end
    end

    assign start = req_s2_r ^ req_s3_r;

    // ======================================================
    // Chip select filter and output enable
    logic [1:0] filt_cnt_r;
    logic [1:0] filt_cnt_nxt;
    logic       cs_low_r;
    logic       cs_low_nxt;
    logic       cs_moved;
    logic       cs_settled;

    assign cs_moved     = (~cs_s2_r) != cs_low_r;
    assign cs_settled   = cs_moved & (filt_cnt_r == `CS_FILT_LAST);
    assign filt_cnt_nxt = (cs_moved & ~cs_settled) ? filt_cnt_r + 2'd1
                                                   : 2'd0;
    assign cs_low_nxt   = cs_settled ? ~cs_s2_r : cs_low_r;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            filt_cnt_r <= 2'd0;
            cs_low_r   <= 1'b0;
        end else begin
            filt_cnt_r <= filt_cnt_nxt;
            cs_low_r   <= cs_low_nxt;
        end
    end

    assign data_oe = cs_low_r;

    // ======================================================
    // Sample hold and saturation
    code_t                code;
    code_t                hold_r;
    logic [`AIN_BITS-1:0] ain_ofs;
    logic                 ain_over;
    logic                 ain_under;

    assign ain_over  = (ain_s2_r >= `REF_HI);
    assign ain_under = (ain_s2_r < `REF_LO);
    assign ain_ofs   = ain_s2_r - `REF_LO;
    assign code      = ain_over  ? `CODE_MAX :
                       ain_under ? `CODE_MIN : ain_ofs[7:0];

    // ======================================================
    // Successive-approximation sequencer
    conv_state_t state_r;
    conv_state_t state_nxt;
    logic [5:0]  conv_cnt_r;
    code_t       sar_r;
    code_t       sar_nxt;
    code_t       trial_r;
    code_t       trial_nxt;
    code_t       guess;
    logic        decide;
    logic        conv_end;
    logic        idle_start;

    result_buf_if rbi ();

    assign idle_start = start & (state_r == CONV_IDLE);
    assign guess      = sar_r | trial_r;
    assign decide     = (state_r == CONV_RUN) &
                        (conv_cnt_r >= `CONV_FIRST_DEC) &
                        (conv_cnt_r[1:0] == `STEP_PHASE);
    assign conv_end   = (state_r == CONV_RUN) &
                        (conv_cnt_r == `CONV_LAST);
    assign sar_nxt    = idle_start ? `RESULT_RST :
                        !decide    ? sar_r :
                        (hold_r >= guess) ? guess : sar_r;
    assign trial_nxt  = idle_start ? `TRIAL_RST :
                        decide     ? (trial_r >> 1) : trial_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CONV_IDLE: begin
                if (start) begin
                    state_nxt = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (conv_end) begin
                    state_nxt = CONV_DONE;
                end
            end
            CONV_DONE: begin
                if (rbi.push_ready) begin
                    state_nxt = CONV_IDLE;
                end
            end
        endcase
    end

    // Runs on the internal clock only, so the shift clock rate has
    // no say in conversion timing.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r    <= CONV_IDLE;
            conv_cnt_r <= 6'd0;
            sar_r      <= `RESULT_RST;
            trial_r    <= `TRIAL_RST;
            hold_r     <= `RESULT_RST;
        end else begin
            state_r    <= state_nxt;
            conv_cnt_r <= (state_r == CONV_RUN) ? conv_cnt_r + 6'd1
                                                : 6'd0;
            sar_r      <= sar_nxt;
            trial_r    <= trial_nxt;
            if (samp_s2_r & (state_r == CONV_IDLE)) begin
                hold_r <= code;
            end
        end
    end

    // ======================================================
    // Result buffer and the word being shifted out
    code_t tx_word_r;
    logic  consumed_r;
    logic  pop_fire;

    assign rbi.push_valid = (state_r == CONV_DONE);
    assign rbi.push_data  = sar_r;
    assign rbi.pop_ready  = consumed_r & ~start;
    assign pop_fire       = rbi.pop_valid & rbi.pop_ready;

    result_buf u_buf (
        .clock  (clock),
        .resetn (resetn),
        .rb     (rbi)
    );

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_word_r  <= `RESULT_RST;
            consumed_r <= 1'b0;
        end else begin
            if (pop_fire) begin
                tx_word_r <= rbi.pop_data;
            end
            consumed_r <= start | (consumed_r & ~pop_fire);
        end
    end

    // The word is stable for the whole frame, so the link side reads
    // it without a crossing; the bit select comes from a link flop.
    // Before the first edge the count is zero and the MSB shows.
    assign data_out = tx_word_r[~edge_cnt_r];

    // ======================================================
    // Checks
    sequence cs_high_run;
        cs_s2_r [*3];
    endsequence

    sequence conv_body;
        (state_r == CONV_RUN) ##35 (state_r == CONV_RUN) ##1
        (state_r == CONV_DONE);
    endsequence

    a_conv_length: assert property (
        @(posedge clock) disable iff (!resetn)
        idle_start |=> conv_body
    ) else $error("conversion did not take 36 clocks");

    a_conv_time_bound: assert property (
        @(posedge clock) disable iff (!resetn)
        idle_start |-> ##[1:CONV_MAX] rbi.push_valid
    ) else $error("conversion exceeded its time limit");

    a_cs_filter: assert property (
        @(posedge clock) disable iff (!resetn)
        $rose(cs_low_r) |-> (!$past(cs_s2_r, 1) && !$past(cs_s2_r, 2)
                             && !$past(cs_s2_r, 3))
    ) else $error("output enabled before chip select settled");

    a_oe_release: assert property (
        @(posedge clock) disable iff (!resetn)
        cs_high_run |=> !data_oe
    ) else $error("output still driven with chip select high");

    a_sample_hold: assert property (
        @(posedge clock) disable iff (!resetn)
        (state_r == CONV_RUN) |=> $stable(hold_r)
    ) else $error("held sample changed during conversion");

    a_word_source: assert property (
        @(posedge clock) disable iff (!resetn)
        $changed(tx_word_r) |-> $past(pop_fire)
    ) else $error("shifted word changed without a finished result");

    // Checked at the held sample, so a broken hold path trips it too.
    a_sat_codes: assert property (
        @(posedge clock) disable iff (!resetn)
        (samp_s2_r && (state_r == CONV_IDLE)) |=>
        ((hold_r == `CODE_MAX) || !$past(ain_over)) &&
        ((hold_r == `CODE_MIN) || !$past(ain_under))
    ) else $error("out-of-range input did not saturate");

    a_result_stall: assert property (
        @(posedge clock) disable iff (!resetn)
        (state_r == CONV_DONE && !rbi.push_ready) |=>
        (state_r == CONV_DONE && $stable(sar_r))
    ) else $error("result lost while buffer full");

    a_sar_result: assert property (
        @(posedge clock) disable iff (!resetn)
        rbi.push_valid |-> (sar_r == hold_r)
    ) else $error("search result differs from held sample");

endmodule

`default_nettype wire

//--- dv/host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Host side of the serial link
module host_model (
    // Internal clock, used only to pace chip select
    input  wire logic clock,
    // Serial link
    output logic      shift_clk,
    output logic      chip_sel_n,
    input  wire logic data_out,
    input  wire logic data_oe
);
    logic seen;

    // A released line reads as the opposite level, so a stale bit never
    // passes for a driven one.
    assign seen = data_oe ? data_out : ~data_out;

    initial begin
        shift_clk  = 1'b0;
        chip_sel_n = 1'b1;
    end

    // Only chip select and the shift clock are driven.
    task automatic select(input logic level);
        @(posedge clock);
        chip_sel_n <= level;
    endtask

    // The shift clock runs only inside a frame and idles low.
    task automatic frame(input int edges, output logic [7:0] word,
                         output logic oe);
        word = 8'h00;
        select(1'b0);
        repeat (15) @(posedge clock);
        oe = data_oe;
        for (int k = 0; k < edges; k++) begin
            #32 shift_clk = 1'b1;
            #16 word[7-k] = seen;
            #16 shift_clk = 1'b0;
        end
        select(1'b1);
        // A fixed wait covers the longest conversion.
        repeat (200) @(posedge clock);
    endtask
endmodule

`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Bench
module tb_top;
    import adc_readout_pkg::*;

    logic       clock;
    logic       resetn;
    logic       shift_clk;
    logic       chip_sel_n;
    logic       data_out;
    logic       data_oe;
    logic [9:0] analog_in;
    int         fail_count = 0;
    int         samples_checked = 0;
    code_t      prev_code;

    initial clock = 1'b0;
    always #50 clock = ~clock;

    serial_adc_readout uut (
        .clock      (clock),
        .resetn     (resetn),
        .shift_clk  (shift_clk),
        .chip_sel_n (chip_sel_n),
        .data_out   (data_out),
        .data_oe    (data_oe),
        .analog_in  (analog_in)
    );

    host_model u_host (
        .clock      (clock),
        .shift_clk  (shift_clk),
        .chip_sel_n (chip_sel_n),
        .data_out   (data_out),
        .data_oe    (data_oe)
    );

    // ======================================================
    // Comparison and closing
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string msg);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, msg, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic code_t code_of(input logic [9:0] a);
        if (a < 10'h080)
            return 8'h00;
        if (a >= 10'h180)
            return 8'hff;
        return a[7:0] - 8'h80;
    endfunction

    // ======================================================
    // Scenarios
    task automatic oe_timing;
        u_host.select(1'b0);
        repeat (2) @(posedge clock);
        #1 check({7'h00, data_oe}, 8'h00, "enable too early");
        repeat (6) @(posedge clock);
        #1 check({7'h00, data_oe}, 8'h01, "enable missing");
        check({7'h00, data_out}, {7'h00, prev_code[7]}, "msb");
        u_host.select(1'b1);
        repeat (2) @(posedge clock);
        #1 check({7'h00, data_oe}, 8'h01, "release too early");
        repeat (6) @(posedge clock);
        #1 check({7'h00, data_oe}, 8'h00, "not released");
        repeat (200) @(posedge clock);
    endtask

    // The word read now is the one converted during the previous frame.
    task automatic full_frame(input logic [9:0] a);
        logic [7:0] word;
        logic       oe;
        code_t      exp;
        exp = prev_code;
        @(posedge clock);
        analog_in <= a;
        u_host.frame(8, word, oe);
        check({7'h00, oe}, 8'h01, "frame enable");
        check(word, exp, "shifted word");
        prev_code = code_of(a);
    endtask

    // Fewer than eight edges must leave the stored word untouched.
    task automatic short_frame;
        logic [7:0] word;
        logic       oe;
        u_host.frame(3, word, oe);
        check(word & 8'he0, prev_code & 8'he0, "short frame");
    endtask

    // ======================================================
    // Main sequence
    initial begin
        resetn    = 1'b0;
        analog_in = 10'h000;
        prev_code = 8'h00;
        repeat (3) @(posedge clock);
        #1 check({7'h00, data_oe}, 8'h00, "enable in reset");
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        oe_timing();
        full_frame(10'h000);
        full_frame(10'h07f);
        full_frame(10'h080);
        full_frame(10'h17f);
        full_frame(10'h180);
        full_frame(10'h3ff);
        short_frame();
        full_frame(10'h0a5);
        full_frame(10'h15a);
        full_frame(10'h180);
        oe_timing();
        results();
    end

    // Ten frames and two enable checks need about 0.3 ms; a hang is cut well beyond that.
    initial begin
        #2000000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        results();
    end
endmodule

`default_nettype wire
